/* File: rtl/tcu_top.sv */
// Triple counter/timer unit: Timers 0, 1 and 2 with special-register port.
// Assumes one core clock; register reads answer one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module tcu_top (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // Special-register port
  input wire tcu_pkg::tcu_sfr_req_t SFR_REQ,
  output logic [7:0] SFR_RDATA,
  // Interrupt vector acknowledges
  input wire logic ACK_T0,
  input wire logic ACK_T1,
  // External pins
  input wire logic EXT_IRQ0_PIN,
  input wire logic EXT_IRQ1_PIN,
  input wire logic TIMER0_COUNT_PIN,
  input wire logic TIMER1_COUNT_PIN,
  input wire logic TIMER2_COUNT_PIN,
  input wire logic TIMER2_CAPTURE_PIN,
  // Flags and events
  output logic TIMER0_OVERFLOW_FLAG,
  output logic TIMER1_OVERFLOW_FLAG,
  output logic TIMER2_OVERFLOW_FLAG,
  output logic TIMER2_EXT_FLAG,
  output logic ADC_CONVERT_START,
  output logic TIMER2_BAUD_TICK
);
  typedef struct packed {
    logic [7:0] run_flag;
    logic [7:0] mode_cfg;
    logic [7:0] prescale;
    logic [7:0] t2_ctrl;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [7:0] tl2;
    logic [7:0] th2;
    logic [7:0] cap_l;
    logic [7:0] cap_h;
    logic [3:0] div;
    logic half;
    logic [7:0] rdata;
    logic adc_start;
    logic baud_tick;
  } tcu_state_t;

  tcu_state_t s_r;
  tcu_state_t s_nxt;
  logic [tcu_pkg::PIN_COUNT-1:0] pin_vec;
  logic [tcu_pkg::PIN_COUNT-1:0] pin_lvl;
  logic [tcu_pkg::PIN_COUNT-1:0] pin_fall;

  assign pin_vec = {TIMER2_CAPTURE_PIN, TIMER2_COUNT_PIN, TIMER1_COUNT_PIN,
                    TIMER0_COUNT_PIN, EXT_IRQ1_PIN, EXT_IRQ0_PIN};

  tcu_pin_sync #(.W(tcu_pkg::PIN_COUNT)) u_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .pins(pin_vec),
    .level(pin_lvl),
    .fall(pin_fall)
  );

  function automatic logic hit(input tcu_pkg::tcu_sfr_req_t r, input logic [7:0] a);
    hit = r.we && (r.addr == a);
  endfunction

  // One count step of Timer 0 or 1 in modes 13-bit, 16-bit and 8-bit reload
  function automatic tcu_pkg::tcu_step_t t01_step(input logic [1:0] mode, input logic [7:0] th,
                                                  input logic [7:0] tl);
    tcu_pkg::tcu_step_t r;
    logic [12:0] c13;
    logic [15:0] c16;
    r.th = th;
    r.tl = tl;
    r.ovf = 1'b0;
    c13 = {th, tl[4:0]};
    c16 = {th, tl};
    if (mode == tcu_pkg::MODE_13BIT) begin
      r.ovf = &c13; // R20
      c13 = 13'(c13 + 13'h0001);
      r.th = c13[12:5]; // R20
      r.tl = {tl[7:5], c13[4:0]};
    end else if (mode == tcu_pkg::MODE_16BIT) begin
      r.ovf = &c16;
      c16 = 16'(c16 + 16'h0001);
      r.th = c16[15:8];
      r.tl = c16[7:0];
    end else if (mode == tcu_pkg::MODE_8BIT_RELOAD) begin
      r.ovf = &tl; // R21
      r.tl = r.ovf ? th : 8'(tl + 8'h01); // R21
    end
    t01_step = r;
  endfunction

  // Decoded controls
  logic tick12;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic split0;
  logic en0;
  logic en1;
  logic tick0;
  logic tick1;
  logic tick0_sys;
  logic tick1_sys;
  logic baud;
  logic reload_mode;
  logic tick2;
  logic ext_ev;
  logic wr_any;

  always_comb begin
    tick12 = (s_r.div == tcu_pkg::PRESCALE_LAST);
    mode0 = s_r.mode_cfg[tcu_pkg::MC_T0MODE +: 2]; // R25
    mode1 = s_r.mode_cfg[tcu_pkg::MC_T1MODE +: 2]; // R25
    split0 = (mode0 == tcu_pkg::MODE_SPLIT_OR_STOP); // R06
    en0 = s_r.run_flag[tcu_pkg::RF_TR0]
          & (~s_r.mode_cfg[tcu_pkg::MC_TIMER0_PIN_GATING] | pin_lvl[tcu_pkg::PIN_IRQ0]); // R01
    en1 = s_r.run_flag[tcu_pkg::RF_TR1]
          & (~s_r.mode_cfg[tcu_pkg::MC_TIMER1_PIN_GATING] | pin_lvl[tcu_pkg::PIN_IRQ1]); // R01
    tick0_sys = s_r.prescale[tcu_pkg::PS_T0M] | tick12; // R04
    tick1_sys = s_r.prescale[tcu_pkg::PS_T1M] | tick12; // R03
    tick0 = s_r.mode_cfg[tcu_pkg::MC_CT0] ? pin_fall[tcu_pkg::PIN_T0] : tick0_sys; // R02
    tick1 = (s_r.mode_cfg[tcu_pkg::MC_CT1] & ~split0) ? pin_fall[tcu_pkg::PIN_T1] : tick1_sys; // R02
    baud = s_r.t2_ctrl[tcu_pkg::T2_RCLK] | s_r.t2_ctrl[tcu_pkg::T2_UART_TX_RATE_SOURCE]; // R13
    reload_mode = baud | ~s_r.t2_ctrl[tcu_pkg::T2_CPRL]; // R13
    if (s_r.t2_ctrl[tcu_pkg::T2_CT2]) begin
      tick2 = pin_fall[tcu_pkg::PIN_T2]; // R11
    end else if (baud) begin
      tick2 = s_r.half; // R09
    end else begin
      tick2 = s_r.prescale[tcu_pkg::PS_T2M] | tick12; // R11
    end
    ext_ev = pin_fall[tcu_pkg::PIN_T2CAP] & s_r.t2_ctrl[tcu_pkg::T2_TIMER2_EXT_EDGE_ENABLE]
             & s_r.t2_ctrl[tcu_pkg::T2_TR2]; // R15
    wr_any = SFR_REQ.we;
  end

  // Next-state logic
  tcu_pkg::tcu_step_t st0;
  tcu_pkg::tcu_step_t st1;
  logic ovf0;
  logic ovf1;
  logic ovf2;
  logic [15:0] cnt2;

  always_comb begin
    s_nxt = s_r;
    s_nxt.adc_start = 1'b0;
    s_nxt.baud_tick = 1'b0;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf2 = 1'b0;
    st0 = t01_step(mode0, s_r.th0, s_r.tl0);
    st1 = t01_step(mode1, s_r.th1, s_r.tl1);
    cnt2 = {s_r.th2, s_r.tl2};
    s_nxt.div = tick12 ? 4'h0 : 4'(s_r.div + 4'h1);
    s_nxt.half = ~s_r.half;
    // Timer 0
    if (split0) begin
      if (en0 && tick0) begin
        s_nxt.tl0 = 8'(s_r.tl0 + 8'h01); // R06
        ovf0 = &s_r.tl0;
      end
      if (s_r.run_flag[tcu_pkg::RF_TR1] && tick0_sys) begin
        s_nxt.th0 = 8'(s_r.th0 + 8'h01); // R22
        ovf1 = &s_r.th0; // R22
      end
    end else if (en0 && tick0) begin
      s_nxt.th0 = st0.th;
      s_nxt.tl0 = st0.tl;
      ovf0 = st0.ovf;
    end
    // Timer 1
    if (mode1 != tcu_pkg::MODE_SPLIT_OR_STOP && en1 && tick1) begin // R05
      s_nxt.th1 = st1.th;
      s_nxt.tl1 = st1.tl;
      if (!split0) begin
        ovf1 = st1.ovf;
      end
    end
    // Timer 2
    if (s_r.t2_ctrl[tcu_pkg::T2_TR2] && tick2) begin // R19
      if (&cnt2) begin
        ovf2 = 1'b1; // R16
        cnt2 = reload_mode ? {s_r.cap_h, s_r.cap_l} : 16'h0000; // R17
      end else begin
        cnt2 = 16'(cnt2 + 16'h0001); // R11
      end
    end
    if (ext_ev) begin
      if (reload_mode) begin
        cnt2 = {s_r.cap_h, s_r.cap_l}; // R18
      end else begin
        s_nxt.cap_h = s_r.th2; // R14
        s_nxt.cap_l = s_r.tl2; // R14
      end
    end
    s_nxt.th2 = cnt2[15:8];
    s_nxt.tl2 = cnt2[7:0];
    s_nxt.adc_start = ovf2; // R12
    s_nxt.baud_tick = ovf2 & baud;
    // Software writes win over counting
    if (hit(SFR_REQ, tcu_pkg::ADDR_RUN_FLAG_CONTROL)) begin
      s_nxt.run_flag = SFR_REQ.wdata;
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_MODE_CONFIG)) begin
      s_nxt.mode_cfg = SFR_REQ.wdata;
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_PRESCALE)) begin
      s_nxt.prescale = SFR_REQ.wdata & tcu_pkg::PS_WRITABLE; // R07
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T2_CONTROL)) begin
      s_nxt.t2_ctrl = SFR_REQ.wdata;
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T0_LOW)) begin
      s_nxt.tl0 = SFR_REQ.wdata; // R10
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T0_HIGH)) begin
      s_nxt.th0 = SFR_REQ.wdata; // R10
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T1_LOW)) begin
      s_nxt.tl1 = SFR_REQ.wdata; // R10
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T1_HIGH)) begin
      s_nxt.th1 = SFR_REQ.wdata; // R10
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T2_LOW)) begin
      s_nxt.tl2 = SFR_REQ.wdata;
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T2_HIGH)) begin
      s_nxt.th2 = SFR_REQ.wdata;
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T2_CAP_LOW)) begin
      s_nxt.cap_l = SFR_REQ.wdata;
    end
    if (hit(SFR_REQ, tcu_pkg::ADDR_T2_CAP_HIGH)) begin
      s_nxt.cap_h = SFR_REQ.wdata;
    end
    // Flags: acknowledge clears, hardware set wins
    if (ACK_T0) begin
      s_nxt.run_flag[tcu_pkg::RF_TF0] = 1'b0; // R23
    end
    if (ACK_T1) begin
      s_nxt.run_flag[tcu_pkg::RF_TF1] = 1'b0; // R23
    end
    if (ovf0) begin
      s_nxt.run_flag[tcu_pkg::RF_TF0] = 1'b1; // R23
    end
    if (ovf1) begin
      s_nxt.run_flag[tcu_pkg::RF_TF1] = 1'b1; // R23
    end
    if (ovf2 && !baud) begin
      s_nxt.t2_ctrl[tcu_pkg::T2_TF2] = 1'b1; // R16
    end
    if (ext_ev) begin
      s_nxt.t2_ctrl[tcu_pkg::T2_EXF2] = 1'b1;
    end
    // Read answer, registered one cycle after the strobe
    if (SFR_REQ.re) begin
      if (SFR_REQ.addr == tcu_pkg::ADDR_RUN_FLAG_CONTROL) begin
        s_nxt.rdata = s_r.run_flag;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_MODE_CONFIG) begin
        s_nxt.rdata = s_r.mode_cfg;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T0_LOW) begin
        s_nxt.rdata = s_r.tl0;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T1_LOW) begin
        s_nxt.rdata = s_r.tl1;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T0_HIGH) begin
        s_nxt.rdata = s_r.th0;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T1_HIGH) begin
        s_nxt.rdata = s_r.th1;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_PRESCALE) begin
        s_nxt.rdata = s_r.prescale & tcu_pkg::PS_WRITABLE; // R08
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T2_CONTROL) begin
        s_nxt.rdata = s_r.t2_ctrl;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T2_CAP_LOW) begin
        s_nxt.rdata = s_r.cap_l;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T2_CAP_HIGH) begin
        s_nxt.rdata = s_r.cap_h;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T2_LOW) begin
        s_nxt.rdata = s_r.tl2;
      end else if (SFR_REQ.addr == tcu_pkg::ADDR_T2_HIGH) begin
        s_nxt.rdata = s_r.th2;
      end else begin
        s_nxt.rdata = tcu_pkg::RST_UNMAPPED;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r <= '0;
      s_r.run_flag <= tcu_pkg::RST_BYTE;
      s_r.mode_cfg <= tcu_pkg::RST_BYTE;
      s_r.prescale <= tcu_pkg::RST_BYTE;
      s_r.t2_ctrl <= tcu_pkg::RST_BYTE;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  assign SFR_RDATA = s_r.rdata;
  assign TIMER0_OVERFLOW_FLAG = s_r.run_flag[tcu_pkg::RF_TF0];
  assign TIMER1_OVERFLOW_FLAG = s_r.run_flag[tcu_pkg::RF_TF1];
  assign TIMER2_OVERFLOW_FLAG = s_r.t2_ctrl[tcu_pkg::T2_TF2];
  assign TIMER2_EXT_FLAG = s_r.t2_ctrl[tcu_pkg::T2_EXF2];
  assign ADC_CONVERT_START = s_r.adc_start;
  assign TIMER2_BAUD_TICK = s_r.baud_tick;

  // Assertions
  property p_gate_hold;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && !en0 && !wr_any) |=> (s_r.tl0 == $past(s_r.tl0));
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("Timer 0 moved while disabled"); // R01

  property p_t0_div12;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && en0 && !split0 && !s_r.mode_cfg[tcu_pkg::MC_CT0] && !s_r.prescale[tcu_pkg::PS_T0M]
     && !tick12 && !wr_any) |=> $stable(s_r.tl0);
  endproperty
  a_t0_div12: assert property (p_t0_div12) else $error("Timer 0 ticked off the divide-by-12 beat"); // R04

  property p_t1_full;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && en1 && !split0 && mode1 == tcu_pkg::MODE_16BIT && !s_r.mode_cfg[tcu_pkg::MC_CT1]
     && s_r.prescale[tcu_pkg::PS_T1M] && !wr_any)
    |=> ({s_r.th1, s_r.tl1} == 16'($past({s_r.th1, s_r.tl1}) + 16'h0001));
  endproperty
  a_t1_full: assert property (p_t1_full) else $error("Timer 1 missed a full-rate tick"); // R03

  property p_t1_stop;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && mode1 == tcu_pkg::MODE_SPLIT_OR_STOP && !wr_any) |=> $stable({s_r.th1, s_r.tl1});
  endproperty
  a_t1_stop: assert property (p_t1_stop) else $error("Timer 1 counted while stopped"); // R05

  property p_reload8;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && en0 && tick0 && mode0 == tcu_pkg::MODE_8BIT_RELOAD && s_r.tl0 == 8'hFF && !wr_any)
    |=> (s_r.tl0 == $past(s_r.th0)) && TIMER0_OVERFLOW_FLAG;
  endproperty
  a_reload8: assert property (p_reload8) else $error("8-bit reload failed"); // R21

  property p_prescale_read;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && SFR_REQ.re && SFR_REQ.addr == tcu_pkg::ADDR_PRESCALE)
    |=> (SFR_RDATA[7:6] == 2'h0) && (SFR_RDATA[2:0] == 3'h0);
  endproperty
  a_prescale_read: assert property (p_prescale_read) else $error("Prescale unused bits read non-zero"); // R07

  property p_capture;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && ext_ev && !reload_mode && !wr_any)
    |=> ({s_r.cap_h, s_r.cap_l} == $past({s_r.th2, s_r.tl2})) && TIMER2_EXT_FLAG;
  endproperty
  a_capture: assert property (p_capture) else $error("Capture did not copy the count"); // R14

  property p_cap_rollover;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && s_r.t2_ctrl[tcu_pkg::T2_TR2] && tick2 && !reload_mode && {s_r.th2, s_r.tl2} == 16'hFFFF
     && !wr_any) |=> TIMER2_OVERFLOW_FLAG && ({s_r.th2, s_r.tl2} == 16'h0000) ##1 !ADC_CONVERT_START[*1];
  endproperty
  a_cap_rollover: assert property (p_cap_rollover) else $error("Capture-mode rollover wrong"); // R16

  property p_ack_clear;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && ACK_T0 && !ovf0 && !wr_any) |=> !TIMER0_OVERFLOW_FLAG;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("Vector acknowledge did not clear flag"); // R23

  c_t0_flag: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(TIMER0_OVERFLOW_FLAG));
  c_capture: cover property (@(posedge CLK) disable iff (!RESET_N) CE && ext_ev && !reload_mode);
  c_ext_reload: cover property (@(posedge CLK) disable iff (!RESET_N) CE && ext_ev && reload_mode);
  c_adc: cover property (@(posedge CLK) disable iff (!RESET_N) ADC_CONVERT_START);
endmodule
`default_nettype wire

/* File: rtl/tcu_pkg.sv */
// Constants, register map and carrier types for the triple counter/timer unit.
// Assumes one 100 MHz core clock and a byte-wide special-register port.
// Behaviour
// R01 - Pin gating set: timer runs only while run bit and its irq pin high.
// R02 - Counter select set: timer increments on falling edges of its count pin; the code keeps Timer 1 on core ticks while Timer 0 is split.
// R03 - Timer 1 ticks at core clock over 12, or undivided when prescale set.
// R04 - Timer 0 ticks at core clock over 12, or undivided when prescale set.
// R05 - Timer 1 mode: 13-bit, 16-bit, 8-bit reload, or stopped.
// R06 - Timer 0 mode: same codes, but code three splits it in two 8-bit counters.
// R07 - Prescale register top two bits read zero and ignore writes.
// R08 - Software writes zero to prescale low three bits; they read zero.
// R09 - Timer 2 prescale bit ignored in baud mode or counter function.
// R10 - Timers 0 and 1 readable and writable as separate low and high bytes.
// R11 - Timer 2 is a 16-bit up-counter on prescaled ticks or count-pin falls.
// R12 - Timer 2 overflow can start an analog-to-digital conversion.
// R13 - Timer 2 off, baud generator, capture or auto-reload by control bits.
// R14 - Capture mode: capture-pin fall copies the Timer 2 count to capture pair.
// R15 - Capture-pin edges act only while the external-edge enable is set.
// R16 - Capture mode rollover sets the Timer 2 overflow flag.
// R17 - Reload mode rollover sets overflow flag and loads count from capture pair.
// R18 - Reload mode with edge enable: capture-pin fall also forces a reload.
// R19 - Setting the Timer 2 run bit starts counting in the selected mode.
// R20 - 13-bit mode uses high byte and five low bits; rollover sets flag.
// R21 - 8-bit reload: low byte rollover sets flag, reloads low from high.
// R22 - Split Timer 0 high byte: core ticks, Timer 1 run bit, Timer 1 flag.
// R23 - Timer 0/1 flags set on overflow, cleared by software or vector.
// R24 - External pins are synchronised before falling edges are detected.
// R25 - Timer 0 and Timer 1 fields are decoded independently; the code ignores the Timer 1 counter select while Timer 0 is split.
package tcu_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_RUN_FLAG_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE_CONFIG = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_PRESCALE = 8'h8E;
  localparam logic [7:0] ADDR_T2_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_T2_CAP_LOW = 8'hCA;
  localparam logic [7:0] ADDR_T2_CAP_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_T2_LOW = 8'hCC;
  localparam logic [7:0] ADDR_T2_HIGH = 8'hCD;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_UNMAPPED = 8'h00;
  // Mode config fields
  localparam int MC_TIMER1_PIN_GATING = 7;
  localparam int MC_CT1 = 6;
  localparam int MC_T1MODE = 4;
  localparam int MC_TIMER0_PIN_GATING = 3;
  localparam int MC_CT0 = 2;
  localparam int MC_T0MODE = 0;
  // Prescale fields
  localparam int PS_T2M = 5;
  localparam int PS_T1M = 4;
  localparam int PS_T0M = 3;
  localparam logic [7:0] PS_WRITABLE = 8'h38;
  // Run/flag control fields
  localparam int RF_TF1 = 7;
  localparam int RF_TR1 = 6;
  localparam int RF_TF0 = 5;
  localparam int RF_TR0 = 4;
  // Timer 2 control fields
  localparam int T2_TF2 = 7;
  localparam int T2_EXF2 = 6;
  localparam int T2_RCLK = 5;
  localparam int T2_UART_TX_RATE_SOURCE = 4;
  localparam int T2_TIMER2_EXT_EDGE_ENABLE = 3;
  localparam int T2_TR2 = 2;
  localparam int T2_CT2 = 1;
  localparam int T2_CPRL = 0;
  // Mode codes
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT_OR_STOP = 2'h3;
  // Timing counts
  localparam int PRESCALE_DIV = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
  // Pin indices
  localparam int PIN_IRQ0 = 0;
  localparam int PIN_IRQ1 = 1;
  localparam int PIN_T0 = 2;
  localparam int PIN_T1 = 3;
  localparam int PIN_T2 = 4;
  localparam int PIN_T2CAP = 5;
  localparam int PIN_COUNT = 6;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcu_sfr_req_t;

  typedef struct packed {
    logic [7:0] th;
    logic [7:0] tl;
    logic ovf;
  } tcu_step_t;
endpackage

/* File: rtl/tcu_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and falling-edge pulse.
// Assumes pins idle high and change slower than two core clocks.
`timescale 1ns/1ns
`default_nettype none
module tcu_pin_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Pins and results
  input wire logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
    logic [W-1:0] fall;
  } tcu_sync_t;

  tcu_sync_t s_r;
  tcu_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pins;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < W; i++) begin
      s_nxt.fall[i] = 1'b0;
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.filt[i] = s_r.s2[i]; // R24
        s_nxt.fall[i] = s_r.filt[i] & ~s_r.s2[i]; // R24
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '1;
      s_r.fall <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.filt;
  assign fall = s_r.fall;
endmodule
`default_nettype wire

/* File: bench/tcu_pin_model.sv */
// Pin model: external count, gate and capture pins of the timer unit.
// Assumes the bench calls its tasks; every pin idles high.
`timescale 1ns/1ns
`default_nettype none
module tcu_pin_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic [5:0] pins
);
  initial pins = 6'h3f;
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk);
    #1 pins[idx] = v;
  endtask
  // Each level held four cycles so it is sampled
  task automatic fall(input int idx);
    set_pin(idx, 1'h0);
    repeat (4) @(posedge clk);
    #1 pins[idx] = 1'h1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: bench/test_triple_counter_timer_unit.sv */
// Testbench of the triple counter/timer unit.
// Assumes the pin model on the external pins and registers reached by SFR_REQ.
`timescale 1ns/1ns
`default_nettype none
module test_triple_counter_timer_unit;
  typedef struct packed {
    logic [7:0] mc, ps, rf, n;
    logic irq;
    logic [7:0] th0, tl0, tl1, eth0, etl0, etl1;
    logic [1:0] ef;
  } tcu_row_t;
  // Mode, prescale, run, window, gate pin, start counts, expected counts, flags
  localparam tcu_row_t ROWS [8] = '{
    '{8'h11, 8'h08, 8'h50, 8'h75, 1'h1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h78, 8'h0a, 2'h0},
    '{8'h11, 8'h10, 8'h50, 8'h75, 1'h1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h78, 2'h0},
    '{8'h01, 8'h08, 8'h10, 8'h02, 1'h1, 8'h12, 8'hfe, 8'h00, 8'h13, 8'h03, 8'h00, 2'h0},
    '{8'h00, 8'h08, 8'h10, 8'h02, 1'h1, 8'hff, 8'hfe, 8'h00, 8'h00, 8'he3, 8'h00, 2'h1},
    '{8'h02, 8'h08, 8'h10, 8'h02, 1'h1, 8'h80, 8'hfe, 8'h00, 8'h80, 8'h83, 8'h00, 2'h1},
    '{8'h33, 8'h08, 8'h50, 8'h02, 1'h1, 8'hfe, 8'h00, 8'h40, 8'h03, 8'h05, 8'h40, 2'h2},
    '{8'h09, 8'h08, 8'h10, 8'h11, 1'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0},
    '{8'h01, 8'h08, 8'h10, 8'h11, 1'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 2'h0}
  };
  // Address, write data, read-back
  localparam logic [23:0] REGS [9] = '{24'h89_a5a5, 24'h8a_5555, 24'h8b_aaaa, 24'h8c_5a5a, 24'h8d_a5a5,
    24'h8e_f838, 24'h80_7700, 24'hca_3434, 24'hcb_1212};
  logic clk, reset_n, ack0, ack1;
  tcu_pkg::tcu_sfr_req_t req;
  logic [7:0] rdata, rd_v;
  logic [5:0] pins;
  logic tf0, tf1, tf2, exf2, adc, baud;
  int n_errors, checked, adc_n, baud_n, a0;
  tcu_row_t r;
  tcu_top u_tcu_top (.CLK(clk), .RESET_N(reset_n), .CE(1'h1), .SFR_REQ(req), .SFR_RDATA(rdata),
    .ACK_T0(ack0), .ACK_T1(ack1), .EXT_IRQ0_PIN(pins[tcu_pkg::PIN_IRQ0]),
    .EXT_IRQ1_PIN(pins[tcu_pkg::PIN_IRQ1]), .TIMER0_COUNT_PIN(pins[tcu_pkg::PIN_T0]),
    .TIMER1_COUNT_PIN(pins[tcu_pkg::PIN_T1]), .TIMER2_COUNT_PIN(pins[tcu_pkg::PIN_T2]),
    .TIMER2_CAPTURE_PIN(pins[tcu_pkg::PIN_T2CAP]), .TIMER0_OVERFLOW_FLAG(tf0),
    .TIMER1_OVERFLOW_FLAG(tf1), .TIMER2_OVERFLOW_FLAG(tf2), .TIMER2_EXT_FLAG(exf2),
    .ADC_CONVERT_START(adc), .TIMER2_BAUD_TICK(baud));
  tcu_pin_model u_tcu_pin_model (.clk(clk), .pins(pins));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (adc === 1'h1) adc_n++;
    if (baud === 1'h1) baud_n++;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{we: 1'h1, re: 1'h0, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 req = '{we: 1'h0, re: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 req = '0;
    @(posedge clk);
    chk8(rdata, exp);
  endtask
  task automatic pf(input int idx);
    u_tcu_pin_model.fall(idx);
  endtask
  task automatic end_of_test;
    $display("Counts: %0d checked, %0d errors", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    reset_n = 1'h0;
    req = '0;
    ack0 = 1'h0;
    ack1 = 1'h0;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'h1;
    chk1(tf0 | tf1 | tf2 | exf2, 1'h0);
    foreach (REGS[i]) begin
      rchk(REGS[i][23:16], 8'h00);
      wr(REGS[i][23:16], REGS[i][15:8]);
      rchk(REGS[i][23:16], REGS[i][7:0]);
    end
    $display("Test register map done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      u_tcu_pin_model.set_pin(tcu_pkg::PIN_IRQ0, r.irq);
      wr(8'h89, r.mc);
      wr(8'h8e, r.ps);
      wr(8'h8c, r.th0);
      wr(8'h8a, r.tl0);
      wr(8'h8b, r.tl1);
      wr(8'h88, r.rf);
      repeat (r.n) @(posedge clk);
      #1 chk1(tf1, r.ef[1]);
      chk1(tf0, r.ef[0]);
      ack0 = 1'h1;
      ack1 = 1'h1;
      @(posedge clk);
      #1 ack0 = 1'h0;
      ack1 = 1'h0;
      chk1(tf0 | tf1, 1'h0);
      wr(8'h88, 8'h00);
      rchk(8'h8c, r.eth0);
      rchk(8'h8a, r.etl0);
      rchk(8'h8b, r.etl1);
      $display("Test row %0d done", i);
    end
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    repeat (3) pf(tcu_pkg::PIN_T0);
    wr(8'h88, 8'h00);
    rchk(8'h8a, 8'h03);
    $display("Test count pin done");
    wr(8'h8e, 8'h20);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    a0 = adc_n;
    wr(8'hc8, 8'h05);
    repeat (4) @(posedge clk);
    #1 chk1(tf2, 1'h1);
    chk8(8'(adc_n - a0), 8'h01);
    wr(8'hc8, 8'h07);
    wr(8'hcc, 8'h78);
    wr(8'hcd, 8'h56);
    pf(tcu_pkg::PIN_T2CAP);
    rchk(8'hca, 8'h34);
    wr(8'hc8, 8'h0f);
    pf(tcu_pkg::PIN_T2CAP);
    rchk(8'hca, 8'h78);
    rchk(8'hcb, 8'h56);
    chk1(exf2, 1'h1);
    pf(tcu_pkg::PIN_T2);
    pf(tcu_pkg::PIN_T2);
    rchk(8'hcc, 8'h7a);
    $display("Test timer2 capture done");
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h0e);
    pf(tcu_pkg::PIN_T2);
    chk1(tf2, 1'h1);
    rchk(8'hcc, 8'h78);
    rchk(8'hcd, 8'h56);
    wr(8'hcc, 8'h00);
    pf(tcu_pkg::PIN_T2CAP);
    rchk(8'hcc, 8'h78);
    $display("Test timer2 reload done");
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    a0 = baud_n;
    wr(8'hc8, 8'h14);
    repeat (40) @(posedge clk);
    #1 chk1(tf2, 1'h0);
    chk1(1'(baud_n > a0), 1'h1);
    $display("Test timer2 baud done");
    reset_n = 1'h0;
    repeat (3) @(posedge clk);
    #1 chk1(tf0 | tf1 | tf2 | exf2, 1'h0);
    reset_n = 1'h1;
    rchk(8'hc8, 8'h00);
    rchk(8'h8e, 8'h00);
    $display("Test mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
